/* File: design/brcs_pkg.sv */
package brcs_pkg;
	// Clock rate and the hold time of a soft reset
	localparam int CLK_HZ = 40_000_000;
	localparam int SOFT_RST_NS = 1000;
	// Least time, so round up to whole cycles
	localparam int SOFT_RST_CYC = (SOFT_RST_NS * (CLK_HZ / 1_000_000) + 999) / 1000;

	// Register map, byte addresses
	localparam int ADDR_W = 4;
	localparam logic [ADDR_W-1:0] ADDR_CTRL = 4'h0;
	localparam logic [ADDR_W-1:0] ADDR_STAT = 4'h4;
	localparam logic [ADDR_W-1:0] ADDR_PLL = 4'h8;

	// Control register bits
	localparam int CTRL_CPU_BIT = 0;
	localparam int CTRL_DEV_BIT = 1;

	// Status register fields
	localparam int STAT_BOOT_LSB = 0;
	localparam int STAT_FALLBACK_BIT = 3;
	localparam int STAT_BVALID_BIT = 4;
	localparam int STAT_CLK_LSB = 8;
	localparam int STAT_CVALID_BIT = 11;
	localparam int STAT_CAUSE_LSB = 16;

	// PLL register fields
	localparam int PLL_MULT_LSB = 0;
	localparam int PLL_DIV_LSB = 8;

	// Bus answers
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_DECERR = 2'h3;

	// PLL settings: every input is brought to the same 416 MHz
	localparam logic [7:0] MULT_19M2 = 8'h41;
	localparam logic [7:0] DIV_19M2 = 8'h03;
	localparam logic [7:0] MULT_26M = 8'h10;
	localparam logic [7:0] DIV_26M = 8'h01;
	localparam logic [7:0] MULT_38M4 = 8'h41;
	localparam logic [7:0] DIV_38M4 = 8'h06;
	localparam logic [7:0] MULT_52M = 8'h08;
	localparam logic [7:0] DIV_52M = 8'h01;
	// PLL output in units of 100 kHz
	localparam logic [15:0] PLL_TARGET = 16'h1040;

	// Clock-select strap codes
	localparam logic [2:0] CSEL_XTAL_19M2 = 3'h0;
	localparam logic [2:0] CSEL_EXT_19M2 = 3'h4;
	localparam logic [2:0] CSEL_EXT_26M = 3'h5;
	localparam logic [2:0] CSEL_EXT_38M4 = 3'h6;
	localparam logic [2:0] CSEL_EXT_52M = 3'h7;

	typedef enum logic [1:0] {LVL_LOW, LVL_HIGH, LVL_FLOAT} brcs_lvl_type;
	typedef enum logic [2:0] {
		BOOT_SYNC_MUX, BOOT_ASYNC_MUX, BOOT_USB, BOOT_ASYNC_SRAM, BOOT_I2C, BOOT_SPI
	} brcs_boot_type;
	typedef enum logic [2:0] {
		CLK_XTAL_19M2, CLK_EXT_19M2, CLK_EXT_26M, CLK_EXT_38M4, CLK_EXT_52M
	} brcs_clk_type;
	typedef enum logic [1:0] {CAUSE_HARD, CAUSE_DEVICE, CAUSE_CPU} brcs_cause_type;

	typedef struct packed {
		brcs_boot_type boot;
		logic fallback;
		logic valid;
	} brcs_bootsel_type;

	// Three-level strap pin
	function automatic brcs_lvl_type toLevel(input logic high, input logic float);
		return float ? LVL_FLOAT : (high ? LVL_HIGH : LVL_LOW);
	endfunction : toLevel

	// Boot source from pins 2..0; unknown codes fall back to USB
	function automatic brcs_bootsel_type decodeBoot(input brcs_lvl_type p2,
		input brcs_lvl_type p1, input brcs_lvl_type p0);
		brcs_bootsel_type r;
		r = '{boot: BOOT_USB, fallback: 1'b0, valid: 1'b1};
		case ({p2, p1, p0})
			{LVL_FLOAT, LVL_LOW, LVL_LOW}: r.boot = BOOT_SYNC_MUX;
			{LVL_FLOAT, LVL_LOW, LVL_HIGH}: r.boot = BOOT_ASYNC_MUX;
			{LVL_FLOAT, LVL_HIGH, LVL_HIGH}: r.boot = BOOT_USB;
			{LVL_FLOAT, LVL_LOW, LVL_FLOAT}: r.boot = BOOT_ASYNC_SRAM;
			{LVL_FLOAT, LVL_HIGH, LVL_FLOAT}: r = '{boot: BOOT_I2C, fallback: 1'b1, valid: 1'b1};
			{LVL_HIGH, LVL_FLOAT, LVL_FLOAT}: r.boot = BOOT_I2C;
			{LVL_LOW, LVL_FLOAT, LVL_HIGH}: r = '{boot: BOOT_SPI, fallback: 1'b1, valid: 1'b1};
			default: r.valid = 1'b0;
		endcase
		return r;
	endfunction : decodeBoot

	// Input rate in units of 100 kHz
	function automatic logic [15:0] refRate(input brcs_clk_type c);
		case (c)
			CLK_EXT_26M: return 16'h0104;
			CLK_EXT_38M4: return 16'h0180;
			CLK_EXT_52M: return 16'h0208;
			default: return 16'h00C0;
		endcase
	endfunction : refRate
endpackage : brcs_pkg

/* File: design/brcs_strap_decode.sv */
`timescale 1ns/100ps
`default_nettype none
module brcs_strap_decode import brcs_pkg::*; (
	// Boot straps: pin driven high, pin left floating
	input wire logic [2:0] bootHigh,
	input wire logic [2:0] bootFloat,
	// Clock-select straps
	input wire logic [2:0] clkSel,
	// Decoded boot choice
	output var brcs_bootsel_type bootSel,
	// Decoded clock choice and PLL setting
	output var brcs_clk_type clkSource,
	output logic clkValid,
	output logic [7:0] pllMult,
	output logic [7:0] pllDiv
);
	brcs_lvl_type lvl [3];

	// Boot straps to three-level codes, then to a boot source
	always_comb begin
		for (int i = 0; i < 3; i++) begin
			lvl[i] = toLevel(bootHigh[i], bootFloat[i]);
		end
		bootSel = decodeBoot(lvl[2], lvl[1], lvl[0]);
	end

	// Clock straps pick the source and the PLL ratio
	always_comb begin
		clkSource = CLK_XTAL_19M2;
		clkValid = 1'b1;
		pllMult = MULT_19M2;
		pllDiv = DIV_19M2;
		case (clkSel)
			CSEL_XTAL_19M2: clkSource = CLK_XTAL_19M2;
			CSEL_EXT_19M2: clkSource = CLK_EXT_19M2;
			CSEL_EXT_26M: begin
				clkSource = CLK_EXT_26M;
				pllMult = MULT_26M;
				pllDiv = DIV_26M;
			end
			CSEL_EXT_38M4: begin
				clkSource = CLK_EXT_38M4;
				pllMult = MULT_38M4;
				pllDiv = DIV_38M4;
			end
			CSEL_EXT_52M: begin
				clkSource = CLK_EXT_52M;
				pllMult = MULT_52M;
				pllDiv = DIV_52M;
			end
			// Unlisted codes keep the crystal setting, flagged invalid
			default: clkValid = 1'b0;
		endcase
	end
endmodule : brcs_strap_decode
`default_nettype wire

/* File: design/brcs_axil_slave.sv */
`timescale 1ns/100ps
`default_nettype none
module brcs_axil_slave import brcs_pkg::*; (
	// Clock and reset
	input wire logic clk,
	input wire logic rst,
	// Write address and data
	input wire logic [ADDR_W-1:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	// Write response
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	// Read address and data
	input wire logic [ADDR_W-1:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	// Register file side
	output logic wrEn,
	output logic [ADDR_W-1:0] wrAddr,
	output logic [31:0] wrData,
	output logic [3:0] wrStrb,
	input wire logic wrHit,
	output logic [ADDR_W-1:0] rdAddr,
	input wire logic [31:0] rdData,
	input wire logic rdHit
);
	logic awHeld_q, awHeld_d, wHeld_q, wHeld_d, bValid_q, bValid_d;
	logic rValid_q, rValid_d;
	logic [ADDR_W-1:0] awAddr_q, awAddr_d;
	logic [31:0] wData_q, wData_d, rData_q, rData_d;
	logic [3:0] wStrb_q, wStrb_d;
	logic [1:0] bResp_q, bResp_d, rResp_q, rResp_d;

	// Address and data are parked separately, so either may come first
	assign s_axi_awready = !awHeld_q && !bValid_q;
	assign s_axi_wready = !wHeld_q && !bValid_q;
	assign s_axi_arready = !rValid_q;
	assign wrEn = awHeld_q && wHeld_q && !bValid_q;
	assign wrAddr = awAddr_q;
	assign wrData = wData_q;
	assign wrStrb = wStrb_q;
	assign rdAddr = s_axi_araddr;
	assign s_axi_bvalid = bValid_q;
	assign s_axi_bresp = bResp_q;
	assign s_axi_rvalid = rValid_q;
	assign s_axi_rdata = rData_q;
	assign s_axi_rresp = rResp_q;

	// Channel next state
	always_comb begin
		awHeld_d = awHeld_q;
		wHeld_d = wHeld_q;
		bValid_d = bValid_q;
		awAddr_d = awAddr_q;
		wData_d = wData_q;
		wStrb_d = wStrb_q;
		bResp_d = bResp_q;
		rValid_d = rValid_q;
		rData_d = rData_q;
		rResp_d = rResp_q;
		if (s_axi_awvalid && s_axi_awready) begin
			awHeld_d = 1'b1;
			awAddr_d = s_axi_awaddr;
		end
		if (s_axi_wvalid && s_axi_wready) begin
			wHeld_d = 1'b1;
			wData_d = s_axi_wdata;
			wStrb_d = s_axi_wstrb;
		end
		if (wrEn) begin
			awHeld_d = 1'b0;
			wHeld_d = 1'b0;
			bValid_d = 1'b1;
			bResp_d = wrHit ? RESP_OKAY : RESP_DECERR;
		end
		if (bValid_q && s_axi_bready) begin
			bValid_d = 1'b0;
		end
		if (rValid_q && s_axi_rready) begin
			rValid_d = 1'b0;
		end
		// Unmapped reads return zero with a decode error
		if (s_axi_arvalid && s_axi_arready) begin
			rValid_d = 1'b1;
			rData_d = rdHit ? rdData : 32'h0000_0000;
			rResp_d = rdHit ? RESP_OKAY : RESP_DECERR;
		end
	end

	// Channel registers
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			awHeld_q <= 1'b0;
			wHeld_q <= 1'b0;
			bValid_q <= 1'b0;
			awAddr_q <= '0;
			wData_q <= 32'h0000_0000;
			wStrb_q <= 4'h0;
			bResp_q <= RESP_OKAY;
			rValid_q <= 1'b0;
			rData_q <= 32'h0000_0000;
			rResp_q <= RESP_OKAY;
		end else begin
			awHeld_q <= awHeld_d;
			wHeld_q <= wHeld_d;
			bValid_q <= bValid_d;
			awAddr_q <= awAddr_d;
			wData_q <= wData_d;
			wStrb_q <= wStrb_d;
			bResp_q <= bResp_d;
			rValid_q <= rValid_d;
			rData_q <= rData_d;
			rResp_q <= rResp_d;
		end
	end
endmodule : brcs_axil_slave
`default_nettype wire

/* File: design/boot_reset_clock_strap_control.sv */
// Functional notes
// - Boot straps F00, F01, F11 pick sync mux, async mux, USB boot.
// - F0F async SRAM, F1F I2C with USB fallback, 1FF I2C, 0F1 SPI+fallback.
// - While the reset pin is low every I/O stays released.
// - After hard reset the bootloader configures I/O for the strapped source.
// - Soft reset starts on a control-register write; the bit picks its type.
// - CPU reset restarts the program counter, firmware stays loaded.
// - Whole-device reset acts as a hard reset; firmware reloads.
// - Clock straps 000,100,101,110,111: crystal/ext 19.2, 26, 38.4, 52 MHz.
// - PLL ratio follows the input so the core rate never changes.
//
// The placing of the registers and the AXI4-Lite slave port are this design's own decisions.
`timescale 1ns/100ps
`default_nettype none
module boot_reset_clock_strap_control import brcs_pkg::*; #(
	parameter int SOFT_RST_CYCLES = SOFT_RST_CYC
) (
	// Clock and reset
	input wire logic clk,
	input wire logic rst,
	// Hard reset pin, active low
	input wire logic resetPinN,
	// Boot-select straps: driven high, left floating
	input wire logic [2:0] bootStrapHigh,
	input wire logic [2:0] bootStrapFloat,
	// Clock-select straps
	input wire logic [2:0] clkStrap,
	// Register bus
	input wire logic [ADDR_W-1:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [ADDR_W-1:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	// Reset and boot controls
	output logic ioEnable,
	output logic cpuReset,
	output logic bootLoadReq,
	// Latched boot choice
	output var brcs_boot_type bootSource,
	output logic bootFallbackUsb,
	output logic bootStrapValid,
	// Latched clock choice
	output var brcs_clk_type clkSource,
	output logic clkIsCrystal,
	output logic clkStrapValid,
	output logic [7:0] pllMult,
	output logic [7:0] pllDiv
);
	localparam int CNT_W = $clog2(SOFT_RST_CYCLES + 1);
	localparam logic [CNT_W-1:0] CNT_LAST = CNT_W'(SOFT_RST_CYCLES - 1);

	typedef enum logic [2:0] {
		ST_HOLD, ST_SAMPLE, ST_RUN, ST_CPU_RST, ST_DEV_RST
	} brcs_state_type;

	brcs_state_type state_q, state_d;
	logic [CNT_W-1:0] cnt_q, cnt_d;
	logic ioEnable_q, ioEnable_d, cpuReset_q, cpuReset_d;
	logic bootLoadReq_q, bootLoadReq_d;
	brcs_cause_type cause_q, cause_d;
	brcs_bootsel_type bootSel_q, bootSel_d, bootSelNew;
	brcs_clk_type clk_q, clk_d, clkNew;
	logic clkValid_q, clkValid_d, clkValidNew;
	logic [7:0] mult_q, mult_d, multNew, div_q, div_d, divNew;
	logic wrEn, wrHit, rdHit, ctrlWr, cpuReq, devReq;
	logic [ADDR_W-1:0] wrAddr, rdAddr;
	logic [31:0] wrData, rdData;
	logic [3:0] wrStrb;

	// Register bus front end
	brcs_axil_slave u_bus (
		.clk(clk),
		.rst(rst),
		.s_axi_awaddr(s_axi_awaddr),
		.s_axi_awvalid(s_axi_awvalid),
		.s_axi_awready(s_axi_awready),
		.s_axi_wdata(s_axi_wdata),
		.s_axi_wstrb(s_axi_wstrb),
		.s_axi_wvalid(s_axi_wvalid),
		.s_axi_wready(s_axi_wready),
		.s_axi_bresp(s_axi_bresp),
		.s_axi_bvalid(s_axi_bvalid),
		.s_axi_bready(s_axi_bready),
		.s_axi_araddr(s_axi_araddr),
		.s_axi_arvalid(s_axi_arvalid),
		.s_axi_arready(s_axi_arready),
		.s_axi_rdata(s_axi_rdata),
		.s_axi_rresp(s_axi_rresp),
		.s_axi_rvalid(s_axi_rvalid),
		.s_axi_rready(s_axi_rready),
		.wrEn(wrEn),
		.wrAddr(wrAddr),
		.wrData(wrData),
		.wrStrb(wrStrb),
		.wrHit(wrHit),
		.rdAddr(rdAddr),
		.rdData(rdData),
		.rdHit(rdHit)
	);

	// Strap decoders
	brcs_strap_decode u_dec (
		.bootHigh(bootStrapHigh),
		.bootFloat(bootStrapFloat),
		.clkSel(clkStrap),
		.bootSel(bootSelNew),
		.clkSource(clkNew),
		.clkValid(clkValidNew),
		.pllMult(multNew),
		.pllDiv(divNew)
	);

	// Only the control word is writable; others answer with an error
	assign wrHit = (wrAddr == ADDR_CTRL);
	assign ctrlWr = wrEn && wrHit && wrStrb[0] && (state_q == ST_RUN);
	// request decode
	// Device reset wins if both bits are written at once
	assign devReq = ctrlWr && wrData[CTRL_DEV_BIT];
	assign cpuReq = ctrlWr && wrData[CTRL_CPU_BIT] && !wrData[CTRL_DEV_BIT];

	// Read mux; the control bits read back as busy flags
	always_comb begin
		rdData = 32'h0000_0000;
		rdHit = 1'b1;
		case (rdAddr)
			ADDR_CTRL: begin
				rdData[CTRL_CPU_BIT] = (state_q == ST_CPU_RST);
				rdData[CTRL_DEV_BIT] = (state_q == ST_DEV_RST);
			end
			ADDR_STAT: begin
				rdData[STAT_BOOT_LSB +: 3] = bootSel_q.boot;
				rdData[STAT_FALLBACK_BIT] = bootSel_q.fallback;
				rdData[STAT_BVALID_BIT] = bootSel_q.valid;
				rdData[STAT_CLK_LSB +: 3] = clk_q;
				rdData[STAT_CVALID_BIT] = clkValid_q;
				rdData[STAT_CAUSE_LSB +: 2] = cause_q;
			end
			ADDR_PLL: begin
				rdData[PLL_MULT_LSB +: 8] = mult_q;
				rdData[PLL_DIV_LSB +: 8] = div_q;
			end
			default: rdHit = 1'b0;
		endcase
	end

	// Reset sequencer next state; the pin overrides every other state
	always_comb begin
		state_d = state_q;
		cnt_d = cnt_q;
		cause_d = cause_q;
		bootLoadReq_d = 1'b0;
		unique case (state_q)
			ST_HOLD: begin
				cause_d = CAUSE_HARD;
				if (resetPinN) begin
					state_d = ST_SAMPLE;
				end
			end
			ST_SAMPLE: begin
				state_d = ST_RUN;
				bootLoadReq_d = 1'b1;
			end
			ST_RUN: begin
				cnt_d = '0;
				if (devReq) begin
					state_d = ST_DEV_RST;
					cause_d = CAUSE_DEVICE;
				end else if (cpuReq) begin
					state_d = ST_CPU_RST;
					cause_d = CAUSE_CPU;
				end
			end
			ST_CPU_RST: begin
				cnt_d = cnt_q + 1'b1;
				if (cnt_q == CNT_LAST) begin
					state_d = ST_RUN;
				end
			end
			ST_DEV_RST: begin
				cnt_d = cnt_q + 1'b1;
				if (cnt_q == CNT_LAST) begin
					state_d = ST_SAMPLE;
				end
			end
		endcase
		if (!resetPinN) begin
			state_d = ST_HOLD;
			bootLoadReq_d = 1'b0;
		end
		// I/O stays released until the straps are in and the loader starts
		ioEnable_d = (state_d == ST_RUN) || (state_d == ST_CPU_RST);
		cpuReset_d = (state_d != ST_RUN);
	end

	// Reset sequencer registers
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			state_q <= ST_HOLD;
			cnt_q <= '0;
			cause_q <= CAUSE_HARD;
			bootLoadReq_q <= 1'b0;
			ioEnable_q <= 1'b0;
			cpuReset_q <= 1'b1;
		end else begin
			state_q <= state_d;
			cnt_q <= cnt_d;
			cause_q <= cause_d;
			bootLoadReq_q <= bootLoadReq_d;
			ioEnable_q <= ioEnable_d;
			cpuReset_q <= cpuReset_d;
		end
	end

	always_comb begin
		bootSel_d = bootSel_q;
		clk_d = clk_q;
		clkValid_d = clkValid_q;
		mult_d = mult_q;
		div_d = div_q;
		if (state_q == ST_SAMPLE) begin
			bootSel_d = bootSelNew;
			clk_d = clkNew;
			clkValid_d = clkValidNew;
			mult_d = multNew;
			div_d = divNew;
		end
	end

	// Strap registers; caught by the clock, never by the reset itself
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			bootSel_q <= '{boot: BOOT_USB, fallback: 1'b0, valid: 1'b0};
			clk_q <= CLK_XTAL_19M2;
			clkValid_q <= 1'b0;
			mult_q <= MULT_19M2;
			div_q <= DIV_19M2;
		end else begin
			bootSel_q <= bootSel_d;
			clk_q <= clk_d;
			clkValid_q <= clkValid_d;
			mult_q <= mult_d;
			div_q <= div_d;
		end
	end

	// Outputs
	assign ioEnable = ioEnable_q;
	assign cpuReset = cpuReset_q;
	assign bootLoadReq = bootLoadReq_q;
	assign bootSource = bootSel_q.boot;
	assign bootFallbackUsb = bootSel_q.fallback;
	assign bootStrapValid = bootSel_q.valid;
	assign clkSource = clk_q;
	assign clkIsCrystal = (clk_q == CLK_XTAL_19M2);
	assign clkStrapValid = clkValid_q;
	assign pllMult = mult_q;
	assign pllDiv = div_q;

	default clocking cb @(posedge clk); endclocking
	default disable iff (rst);

	a_boot_usb_code: assert property (
		state_q == ST_SAMPLE && bootStrapFloat == 3'h4 && bootStrapHigh[1:0] == 2'h3
		|=> bootSource == BOOT_USB && !bootFallbackUsb && bootStrapValid)
		else $error("USB boot strap not decoded");
	a_boot_spi_code: assert property (
		state_q == ST_SAMPLE && bootStrapFloat == 3'h2 && bootStrapHigh[2] == 1'b0
		&& bootStrapHigh[0] == 1'b1 |=> bootSource == BOOT_SPI && bootFallbackUsb)
		else $error("SPI boot strap not decoded");
	a_io_tristate: assert property (
		!resetPinN |=> !ioEnable && cpuReset)
		else $error("I/O driven while reset pin low");
	a_loader_start: assert property (
		state_q == ST_SAMPLE && resetPinN |=> bootLoadReq && ioEnable ##1 !bootLoadReq)
		else $error("Loader not started after reset");
	a_soft_start: assert property (
		cpuReq && resetPinN |=> cpuReset && state_q == ST_CPU_RST)
		else $error("CPU soft reset not started");
	a_cpu_keeps_fw: assert property (
		cpuReq |=> (!bootLoadReq && (ioEnable || !resetPinN))[*8])
		else $error("CPU reset reloaded firmware");
	a_dev_reload: assert property (
		devReq |=> !ioEnable ##[1:100] (bootLoadReq || !resetPinN))
		else $error("Device reset did not reload");
	a_clk_52m: assert property (
		state_q == ST_SAMPLE && clkStrap == CSEL_EXT_52M
		|=> clkSource == CLK_EXT_52M && !clkIsCrystal)
		else $error("52 MHz strap not decoded");
	a_pll_rate: assert property (
		clkStrapValid |-> refRate(clkSource) * pllMult == PLL_TARGET * pllDiv)
		else $error("PLL output rate differs");
	a_straps_held: assert property (
		state_q != ST_SAMPLE |=> $stable(bootSource) && $stable(clkSource))
		else $error("Straps changed outside sampling");

	c_cpu_reset: cover property (cpuReq ##[1:100] state_q == ST_RUN);
	c_dev_reset: cover property (devReq ##[1:100] bootLoadReq);
	c_i2c_fallback: cover property (bootSource == BOOT_I2C && bootFallbackUsb);
endmodule : boot_reset_clock_strap_control
`default_nettype wire

/* File: bench/brcs_strap_model.sv */
`timescale 1ns/100ps
`default_nettype none
module brcs_strap_model (
	// Clock
	input wire logic clk,
	// Wiring the board wants, and the reset button
	input wire logic [2:0] wantHigh,
	input wire logic [2:0] wantFloat,
	input wire logic [2:0] wantClk,
	input wire logic holdReset,
	// Board pins
	output logic [2:0] bootStrapHigh = 3'h0,
	output logic [2:0] bootStrapFloat = 3'h0,
	output logic [2:0] clkStrap = 3'h0,
	output logic resetPinN = 1'b1
);
	logic flip = 1'b0;

	// A floating pin reads noise, so its high line toggles every cycle
	always @(posedge clk) begin
		flip <= !flip;
		bootStrapHigh <= (wantHigh & ~wantFloat) | (wantFloat & {3{flip}});
		bootStrapFloat <= wantFloat;
		clkStrap <= wantClk;
		resetPinN <= !holdReset;
	end
endmodule : brcs_strap_model
`default_nettype wire

/* File: bench/boot_reset_clock_strap_control_bench.sv */
`timescale 1ns/100ps
`default_nettype none
module boot_reset_clock_strap_control_bench;
	import brcs_pkg::*;
`define CHK(g, e) chkVal(64'(g), 64'(e))
	logic clk, rst = 1'b1;
	logic [ADDR_W-1:0] s_axi_awaddr = '0, s_axi_araddr = '0;
	logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
	logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
	logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
	// Latched choices as the pins show them
	logic [2:0] bootSrc, clkSrc;
	logic bootFb, bootOk, clkOk;
	// Short soft reset keeps the run brief
	localparam int SOFT_CYC = 8;
	logic s_axi_rvalid, ioEnable, cpuReset, bootLoadReq, clkIsCrystal;
	logic [31:0] s_axi_wdata = '0, s_axi_rdata;
	logic [3:0] s_axi_wstrb = 4'hF;
	logic [1:0] s_axi_bresp, s_axi_rresp;
	logic [7:0] pllMult, pllDiv;
	logic [2:0] wantHigh, wantFloat, wantClk, bootStrapHigh, bootStrapFloat, clkStrap;
	logic holdReset = 1'b0, resetPinN;
	logic [33:0] notes[$];
	int numErrors = 0, testsRun = 0, cycles = 0, cpuCnt = 0, loadCnt = 0, ioLowCnt = 0;
	int seed = 87, c0, l0, o0;
	// Boot table: float pins, high pins, source, fallback, valid
	localparam logic [10:0] BT[8] = '{11'b100_000_000_0_1, 11'b100_001_001_0_1,
		11'b100_011_010_0_1, 11'b101_000_011_0_1, 11'b101_010_100_1_1,
		11'b011_100_100_0_1, 11'b010_001_101_1_1, 11'b000_000_010_0_0};
	// Clock table: strap code, source, valid
	localparam logic [6:0] CT[6] = '{7'b000_000_1, 7'b100_001_1, 7'b101_010_1,
		7'b110_011_1, 7'b111_100_1, 7'b001_000_0};
	localparam logic [7:0] MUL[5] = '{MULT_19M2, MULT_19M2, MULT_26M, MULT_38M4, MULT_52M};
	localparam logic [7:0] DIV[5] = '{DIV_19M2, DIV_19M2, DIV_26M, DIV_38M4, DIV_52M};
	localparam int RATE[5] = '{192, 192, 260, 384, 520};

	brcs_strap_model u_brcs_strap_model (.clk, .wantHigh, .wantFloat, .wantClk, .holdReset,
		.bootStrapHigh, .bootStrapFloat, .clkStrap, .resetPinN);

	boot_reset_clock_strap_control #(.SOFT_RST_CYCLES(SOFT_CYC)) u_boot_reset_clock_strap_control (
		.clk, .rst, .resetPinN, .bootStrapHigh, .bootStrapFloat, .clkStrap,
		.s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
		.s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
		.s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
		.s_axi_rvalid, .s_axi_rready, .ioEnable, .cpuReset, .bootLoadReq, .bootSource(bootSrc),
		.bootFallbackUsb(bootFb), .bootStrapValid(bootOk), .clkSource(clkSrc), .clkIsCrystal,
		.clkStrapValid(clkOk), .pllMult, .pllDiv);

	task automatic chkVal(input logic [63:0] g, input logic [63:0] e);
		testsRun++;
		if (g !== e) begin
			numErrors++;
			$display("CHECK FAILED t=%0t got=%h exp=%h", $time, g, e);
		end
	endtask : chkVal

	task automatic give_verdict();
		$display("errors=%0d checks=%0d", numErrors, testsRun);
		if (numErrors == 0 && testsRun > 0) $display("ALL CHECKS OK");
		else $display("CHECKS NOT OK");
		$finish;
	endtask : give_verdict

	function automatic logic [31:0] stat(logic [10:0] b, logic [6:0] c, logic [1:0] cause);
		return {14'h0, cause, 4'h0, c[0], c[3:1], 3'h0, b[0], b[1], b[4:2]};
	endfunction : stat

	// Each half is released on its own edge; the response ends the cycle
	task automatic axiWrite(input logic [3:0] a, input logic [31:0] d, input logic [1:0] r);
		@(posedge clk);
		notes.push_back({r, 32'h0});
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		do begin
			@(posedge clk);
			if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
			if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
		end while (s_axi_bvalid !== 1'b1);
		s_axi_bready <= 1'b0;
	endtask : axiWrite

	task automatic axiRead(input logic [3:0] a, input logic [33:0] e);
		@(posedge clk);
		notes.push_back(e);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		do begin
			@(posedge clk);
			if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
		end while (s_axi_rvalid !== 1'b1);
		s_axi_rready <= 1'b0;
	endtask : axiRead

	task automatic waitLoad();
		int n = 0;
		do begin
			@(posedge clk);
			n++;
		end while (bootLoadReq !== 1'b1 && n < 100);
		`CHK(bootLoadReq, 1'b1);
	endtask : waitLoad

	task automatic checkState(input int i, input int j, input logic [1:0] cause);
		int s;
		s = CT[j][3:1];
		@(posedge clk);
		`CHK({ioEnable, cpuReset}, 2'b10);
		`CHK(clkIsCrystal, s == 0);
		`CHK({clkSrc, clkOk}, CT[j][3:0]);
		`CHK({bootSrc, bootFb, bootOk}, BT[i][4:0]);
		`CHK(pllMult * RATE[s] / pllDiv, PLL_TARGET);
		axiRead(ADDR_STAT, {RESP_OKAY, stat(BT[i], CT[j], cause)});
		axiRead(ADDR_PLL, {RESP_OKAY, 16'h0, DIV[s], MUL[s]});
	endtask : checkState

	task automatic setStraps(input int i, input int j);
		wantFloat <= BT[i][10:8];
		wantHigh <= BT[i][7:5];
		wantClk <= CT[j][6:4];
	endtask : setStraps

	initial begin
		clk = 1'b0;
		forever #12.5 clk = ~clk;
	end

	// Scoreboard: oldest note against each bus answer, plus event counters
	always @(posedge clk) begin
		if (s_axi_rvalid && s_axi_rready) begin
			`CHK({s_axi_rresp, s_axi_rdata}, notes.pop_front());
		end
		if (s_axi_bvalid && s_axi_bready) begin
			`CHK({s_axi_bresp, 32'h0}, notes.pop_front());
		end
		cpuCnt += (cpuReset === 1'b1);
		loadCnt += (bootLoadReq === 1'b1);
		ioLowCnt += (ioEnable !== 1'b1);
		cycles++;
		if (cycles == 5000) begin
			numErrors++;
			give_verdict();
		end
	end

	initial begin
		setStraps(2, 0);
		repeat (3) @(posedge clk);
		`CHK({ioEnable, cpuReset}, 2'b01);
		repeat (3) @(posedge clk);
		rst <= 1'b0;
		waitLoad();
		checkState(2, 0, 2'h0);
		// Every boot code, every clock code, each through the reset pin
		for (int i = 0; i < 8; i++) begin
			@(posedge clk);
			setStraps(i, i % 6);
			holdReset <= 1'b1;
			repeat (4) @(posedge clk);
			`CHK({ioEnable, cpuReset}, 2'b01);
			holdReset <= 1'b0;
			waitLoad();
			checkState(i, i % 6, 2'h0);
		end
		// CPU reset: noisy straps must not be taken up
		wantHigh <= 3'($random(seed));
		wantFloat <= 3'($random(seed));
		wantClk <= 3'($random(seed));
		c0 = cpuCnt;
		l0 = loadCnt;
		o0 = ioLowCnt;
		axiWrite(ADDR_CTRL, 32'h1, RESP_OKAY);
		`CHK(cpuReset, 1'b1);
		axiRead(ADDR_CTRL, {RESP_OKAY, 32'h1});
		repeat (20) @(posedge clk);
		`CHK(cpuCnt - c0, SOFT_CYC);
		`CHK(loadCnt - l0, 0);
		`CHK(ioLowCnt - o0, 0);
		axiRead(ADDR_STAT, {RESP_OKAY, stat(BT[7], CT[1], 2'h2)});
		// Device reset wins over CPU reset and re-reads the straps
		setStraps(5, 4);
		o0 = ioLowCnt;
		axiWrite(ADDR_CTRL, 32'h3, RESP_OKAY);
		`CHK({ioEnable, cpuReset}, 2'b01);
		// A request while a reset runs is answered but has no effect
		axiWrite(ADDR_CTRL, 32'h1, RESP_OKAY);
		waitLoad();
		checkState(5, 4, 2'h1);
		// I/O stays released for the hold time plus the sample cycle
		`CHK(ioLowCnt - o0, SOFT_CYC + 1);
		// Unmapped and read-only places
		axiRead(4'hC, {RESP_DECERR, 32'h0});
		axiWrite(ADDR_STAT, 32'hFFFF_FFFF, RESP_DECERR);
		axiWrite(ADDR_PLL, 32'h0, RESP_DECERR);
		axiWrite(4'hC, 32'h3, RESP_DECERR);
		axiRead(ADDR_PLL, {RESP_OKAY, 16'h0, DIV_52M, MULT_52M});
		`CHK(ioEnable, 1'b1);
		give_verdict();
	end
`undef CHK
endmodule : boot_reset_clock_strap_control_bench
`default_nettype wire
